// ===== logic/vtc_regs.svh
// Register offsets, field positions, reset values and fixed counts.
`ifndef VTC_REGS_SVH
`define VTC_REGS_SVH
`define VTC_OFF_MGMT 8'h00
`define VTC_OFF_UNTAG 8'h04
`define VTC_OFF_PRIO 8'h08
`define VTC_OFF_STAT 8'h0c
`define VTC_OFF_TIDX 8'h10
`define VTC_OFF_TDATA 8'h14
`define VTC_OFF_PORT_DEFAULT_VLAN_ID 8'h20
`define VTC_TAB_VALID_BIT 31
`define VTC_TAB_MEM_LSB 12
`define VTC_TPID 16'h8100
`define VTC_RST_VID 12'h001
`define VTC_RST_UNTAG 8'hff
`define VTC_RST_MEMBERS 8'hff
`define VTC_RST_PRIO 3'h0
`define VTC_NPORT 8
`define VTC_NVLAN 255
`define VTC_LAST_IDX 8'hfe
`define VTC_HDR_LEN 5'h10
`define VTC_HDR_LAST 5'h0f
`define VTC_TAG_POS 5'h0c
`define VTC_CRC_INIT 32'hffffffff
`define VTC_CRC_POLY 32'hedb88320
`endif

// ===== logic/vtc_pkg.sv
// Types shared by the VLAN tag classifier and editor.
`default_nettype none
package vtc_pkg;
	typedef enum logic [2:0] {
		ST_HDR,
		ST_LOOK,
		ST_HEAD,
		ST_BODY,
		ST_FCS,
		ST_DROP
	} vtc_state_t;
	typedef logic [11:0] vtc_vid_t;
	typedef logic [2:0] vtc_port_t;
endpackage
`default_nettype wire

// ===== logic/vtc_crc32.sv
// Byte-wise Ethernet frame check sequence accumulator.
`default_nettype none
`include "vtc_regs.svh"
module vtc_crc32 (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic crc_clr,
	input wire logic crc_en,
	input wire logic [7:0] crc_byte,
	output logic [31:0] crc_value
);
	logic [31:0] crc_reg;
	logic [31:0] crc_seed;

	function automatic logic [31:0] crc_step(input logic [31:0] c,
		input logic [7:0] d);
		logic [31:0] r;
		r = c ^ {24'h000000, d};
		for (int i = 0; i < 8; i++)
		begin
			r = r[0] ? ((r >> 1) ^ `VTC_CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction

	assign crc_seed = crc_clr ? `VTC_CRC_INIT : crc_reg;
	assign crc_value = crc_reg;

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			crc_reg <= `VTC_CRC_INIT;
		else if (crc_en)
			crc_reg <= crc_step(crc_seed, crc_byte);
		else if (crc_clr)
			crc_reg <= `VTC_CRC_INIT;
	end
endmodule
`default_nettype wire

// ===== logic/vtc_top.sv
// VLAN tag classifier, egress filter and tag editor with register slave.
//
// Chosen here: the placing of the registers and the Avalon-MM register port.
`default_nettype none
`include "vtc_regs.svh"
module vtc_top (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [7:0] in_data,
	input wire logic in_valid,
	input wire logic in_sop,
	input wire logic in_eop,
	input wire vtc_pkg::vtc_port_t in_port,
	input wire vtc_pkg::vtc_port_t in_egress,
	output logic in_ready,
	output logic [7:0] out_data,
	output logic out_valid,
	output logic out_sop,
	output logic out_eop,
	output vtc_pkg::vtc_vid_t out_vid,
	output logic [2:0] out_prio,
	output logic out_canonical,
	output logic out_mgmt
);
	import vtc_pkg::*;

	function automatic logic sel(input logic [7:0] a, input logic [7:0] off);
		return a[7:2] == off[7:2];
	endfunction

	vtc_state_t state_reg, state_next;
	logic [7:0] hdr_reg [0:15];
	logic [4:0] hlen_reg, rd_ptr_reg;
	logic hdr_eop_reg, tag_done_reg, in_ready_reg, wait_reg;
	vtc_port_t in_port_reg, eg_port_reg;
	logic [7:0] look_idx_reg;
	logic [1:0] tag_cnt_reg, fcs_cnt_reg;
	vtc_vid_t tab_vid [0:`VTC_NVLAN-1];
	logic [7:0] tab_mem [0:`VTC_NVLAN-1];
	logic tab_val [0:`VTC_NVLAN-1];
	vtc_vid_t port_default_vlan_id_reg [0:`VTC_NPORT-1];
	vtc_vid_t mgmt_reg;
	logic [7:0] untag_reg, tidx_reg;
	logic [2:0] prio_reg;
	logic [15:0] fwd_cnt_reg, drop_cnt_reg;
	logic [31:0] rd_data_reg;
	logic [7:0] out_data_reg;
	logic out_valid_reg, out_sop_reg, out_eop_reg, out_mgmt_reg;
	vtc_vid_t out_vid_reg;
	logic [2:0] out_prio_reg;
	logic out_cfi_reg;
	logic [31:0] crc_value;

	// Ingress classification from the held header.
	wire logic hdr_tagged = (hlen_reg == `VTC_HDR_LEN) &&
		({hdr_reg[12], hdr_reg[13]} == `VTC_TPID);
	wire logic [2:0] user_prio = hdr_reg[14][7:5];
	wire logic canonical_format_bit = hdr_reg[14][4];
	wire vtc_vid_t tci_vid = {hdr_reg[14][3:0], hdr_reg[15]};
	// A priority-only tag carries identifier zero and falls back to the port.
	wire logic use_tag = hdr_tagged && (tci_vid != 12'h000);
	wire vtc_vid_t class_vid = use_tag ? tci_vid :
		port_default_vlan_id_reg[in_port_reg];
	wire logic look_hit = tab_val[look_idx_reg] &&
		(tab_vid[look_idx_reg] == class_vid) &&
		tab_mem[look_idx_reg][eg_port_reg];
	wire logic eg_untag = untag_reg[eg_port_reg];
	wire logic do_insert = !hdr_tagged && !eg_untag;
	wire logic do_strip = hdr_tagged && eg_untag;

	// Egress byte selection.
	wire logic rx_take = in_valid && in_ready_reg;
	wire logic hdr_cap = (state_reg == ST_HDR) && rx_take &&
		((hlen_reg != 5'h00) || in_sop);
	wire logic head_live = (state_reg == ST_HEAD) && (rd_ptr_reg != hlen_reg);
	wire logic at_tag = rd_ptr_reg == `VTC_TAG_POS;
	wire logic head_ins = head_live && at_tag && do_insert && !tag_done_reg;
	wire logic head_skip = head_live && at_tag && do_strip;
	wire logic head_out = head_live && !head_skip;
	wire logic body_out = (state_reg == ST_BODY) && rx_take;
	wire logic fcs_out = state_reg == ST_FCS;
	wire logic [31:0] tag_word = {`VTC_TPID, prio_reg, 1'b0, class_vid};
	wire logic [31:0] tag_sh = tag_word << {tag_cnt_reg, 3'b000};
	wire logic [31:0] fcs_sh = (~crc_value) >> {fcs_cnt_reg, 3'b000};
	wire logic [7:0] head_byte = head_ins ? tag_sh[31:24] :
		hdr_reg[rd_ptr_reg[3:0]];
	wire logic emit_valid = head_out || body_out || fcs_out;
	wire logic [7:0] emit_data = head_out ? head_byte :
		(body_out ? in_data : fcs_sh[7:0]);
	wire logic emit_sop = head_out && (rd_ptr_reg == 5'h00);
	wire logic emit_eop = fcs_out && (fcs_cnt_reg == 2'h3);

	// The check sequence always covers the bytes actually sent.
	vtc_crc32 u_crc (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.crc_clr(emit_sop),
		.crc_en(emit_valid && !fcs_out),
		.crc_byte(emit_data),
		.crc_value(crc_value)
	);

	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			ST_HDR:
				if (hdr_cap && (in_eop || hlen_reg == `VTC_HDR_LAST))
					state_next = ST_LOOK;
			ST_LOOK:
				if (look_hit)
					state_next = ST_HEAD;
				else if (look_idx_reg == `VTC_LAST_IDX)
					state_next = hdr_eop_reg ? ST_HDR : ST_DROP;
			ST_HEAD:
				if (rd_ptr_reg == hlen_reg)
					state_next = hdr_eop_reg ? ST_FCS : ST_BODY;
			ST_BODY:
				if (rx_take && in_eop)
					state_next = ST_FCS;
			ST_FCS:
				if (fcs_cnt_reg == 2'h3)
					state_next = ST_HDR;
			ST_DROP:
				if (rx_take && in_eop)
					state_next = ST_HDR;
			default:
				state_next = ST_HDR;
		endcase
	end

	wire logic ready_next = (state_next == ST_HDR) ||
		(state_next == ST_BODY) || (state_next == ST_DROP);

	always_ff @(posedge sys_clk)
	begin
		if (hdr_cap)
			hdr_reg[hlen_reg[3:0]] <= in_data;
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_reg <= ST_HDR;
			in_ready_reg <= 1'b0;
			hlen_reg <= 5'h00;
			hdr_eop_reg <= 1'b0;
			in_port_reg <= 3'h0;
			eg_port_reg <= 3'h0;
		end
		else
		begin
			state_reg <= state_next;
			in_ready_reg <= ready_next;
			if (hdr_cap)
			begin
				hlen_reg <= hlen_reg + 5'h01;
				hdr_eop_reg <= in_eop;
			end
			else if (state_reg != ST_HDR && state_next == ST_HDR)
				hlen_reg <= 5'h00;
			if (hdr_cap && hlen_reg == 5'h00)
			begin
				in_port_reg <= in_port;
				eg_port_reg <= in_egress;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			look_idx_reg <= 8'h00;
			rd_ptr_reg <= 5'h00;
			tag_cnt_reg <= 2'h0;
			tag_done_reg <= 1'b0;
			fcs_cnt_reg <= 2'h0;
		end
		else
		begin
			look_idx_reg <= (state_reg == ST_LOOK) ? look_idx_reg + 8'h01 : 8'h00;
			fcs_cnt_reg <= fcs_out ? fcs_cnt_reg + 2'h1 : 2'h0;
			if (state_reg != ST_HEAD)
				rd_ptr_reg <= 5'h00;
			else if (head_skip)
				rd_ptr_reg <= `VTC_HDR_LEN;
			else if (head_out && !head_ins)
				rd_ptr_reg <= rd_ptr_reg + 5'h01;
			tag_cnt_reg <= head_ins ? tag_cnt_reg + 2'h1 : 2'h0;
			if (state_reg != ST_HEAD)
				tag_done_reg <= 1'b0;
			else if (head_ins && tag_cnt_reg == 2'h3)
				tag_done_reg <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			out_data_reg <= 8'h00;
			out_valid_reg <= 1'b0;
			out_sop_reg <= 1'b0;
			out_eop_reg <= 1'b0;
			out_vid_reg <= 12'h000;
			out_prio_reg <= 3'h0;
			out_cfi_reg <= 1'b0;
			out_mgmt_reg <= 1'b0;
			fwd_cnt_reg <= 16'h0000;
			drop_cnt_reg <= 16'h0000;
		end
		else
		begin
			out_data_reg <= emit_data;
			out_valid_reg <= emit_valid;
			out_sop_reg <= emit_sop;
			out_eop_reg <= emit_eop;
			if (state_reg == ST_LOOK)
			begin
				out_vid_reg <= class_vid;
				out_prio_reg <= hdr_tagged ? user_prio : prio_reg;
				out_cfi_reg <= hdr_tagged && canonical_format_bit;
				out_mgmt_reg <= class_vid == mgmt_reg;
			end
			if (state_reg == ST_LOOK && look_hit)
				fwd_cnt_reg <= fwd_cnt_reg + 16'h0001;
			if (state_reg == ST_LOOK && state_next != ST_LOOK && !look_hit)
				drop_cnt_reg <= drop_cnt_reg + 16'h0001;
		end
	end

	// Register slave: one wait cycle, then the answer edge.
	wire logic [7:0] reg_addr = {avs_address[7:2], 2'b00};
	wire logic bus_req = avs_read || avs_write;
	wire logic commit = avs_write && !wait_reg;
	wire logic is_port_default_vlan_id = reg_addr[7:5] == 3'(`VTC_OFF_PORT_DEFAULT_VLAN_ID >> 5);
	wire logic [2:0] port_default_vlan_id_sel = reg_addr[4:2];
	wire logic tidx_ok = tidx_reg != 8'hff;
	wire logic [31:0] tab_word = {tab_val[tidx_reg], 11'h000,
		tab_mem[tidx_reg], tab_vid[tidx_reg]};
	wire logic [31:0] be_mask = {{8{avs_byteenable[3]}},
		{8{avs_byteenable[2]}}, {8{avs_byteenable[1]}},
		{8{avs_byteenable[0]}}};
	wire logic [31:0] rd_word =
		sel(reg_addr, `VTC_OFF_MGMT) ? {20'h00000, mgmt_reg} :
		sel(reg_addr, `VTC_OFF_UNTAG) ? {24'h000000, untag_reg} :
		sel(reg_addr, `VTC_OFF_PRIO) ? {29'h00000000, prio_reg} :
		sel(reg_addr, `VTC_OFF_STAT) ? {drop_cnt_reg, fwd_cnt_reg} :
		sel(reg_addr, `VTC_OFF_TIDX) ? {24'h000000, tidx_reg} :
		sel(reg_addr, `VTC_OFF_TDATA) ? (tidx_ok ? tab_word : 32'h0) :
		is_port_default_vlan_id ? {20'h00000, port_default_vlan_id_reg[port_default_vlan_id_sel]} : 32'h00000000;
	wire logic [31:0] wval = (rd_word & ~be_mask) | (avs_writedata & be_mask);
	wire logic [7:0] new_mem = wval[`VTC_TAB_MEM_LSB +: 8];
	wire logic tab_wr = commit && sel(reg_addr, `VTC_OFF_TDATA) && tidx_ok;
	// A second VLAN claiming ports takes them out of the default VLAN.
	wire logic leave_dflt = tab_wr && (tidx_reg != 8'h00) &&
		wval[`VTC_TAB_VALID_BIT] && (wval[11:0] != `VTC_RST_VID);

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wait_reg <= 1'b1;
			rd_data_reg <= 32'h00000000;
		end
		else
		begin
			wait_reg <= !(bus_req && wait_reg);
			if (avs_read && wait_reg)
				rd_data_reg <= rd_word;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			for (int i = 0; i < `VTC_NVLAN; i++)
			begin
				tab_vid[i] <= 12'h000;
				tab_mem[i] <= 8'h00;
				tab_val[i] <= 1'b0;
			end
			tab_vid[0] <= `VTC_RST_VID;
			tab_mem[0] <= `VTC_RST_MEMBERS;
			tab_val[0] <= 1'b1;
			for (int p = 0; p < `VTC_NPORT; p++)
				port_default_vlan_id_reg[p] <= `VTC_RST_VID;
			mgmt_reg <= `VTC_RST_VID;
			untag_reg <= `VTC_RST_UNTAG;
			prio_reg <= `VTC_RST_PRIO;
			tidx_reg <= 8'h00;
		end
		else
		begin
			if (commit && sel(reg_addr, `VTC_OFF_MGMT))
				mgmt_reg <= wval[11:0];
			if (commit && sel(reg_addr, `VTC_OFF_UNTAG))
				untag_reg <= wval[7:0];
			if (commit && sel(reg_addr, `VTC_OFF_PRIO))
				prio_reg <= wval[2:0];
			if (commit && sel(reg_addr, `VTC_OFF_TIDX))
				tidx_reg <= wval[7:0];
			if (commit && is_port_default_vlan_id)
				port_default_vlan_id_reg[port_default_vlan_id_sel] <= wval[11:0];
			if (tab_wr)
			begin
				tab_vid[tidx_reg] <= wval[11:0];
				tab_mem[tidx_reg] <= new_mem;
				tab_val[tidx_reg] <= wval[`VTC_TAB_VALID_BIT];
			end
			if (leave_dflt)
				tab_mem[0] <= tab_mem[0] & ~new_mem;
		end
	end

	assign avs_waitrequest = wait_reg;
	assign avs_readdata = rd_data_reg;
	assign in_ready = in_ready_reg;
	assign out_data = out_data_reg;
	assign out_valid = out_valid_reg;
	assign out_sop = out_sop_reg;
	assign out_eop = out_eop_reg;
	assign out_vid = out_vid_reg;
	assign out_prio = out_prio_reg;
	assign out_canonical = out_cfi_reg;
	assign out_mgmt = out_mgmt_reg;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	untag_class_a: assert property (
		(state_reg == ST_LOOK && !hdr_tagged)
		|=> out_vid_reg == port_default_vlan_id_reg[in_port_reg])
		else $error("untagged frame not given port default vlan");
	tag_class_a: assert property (
		(state_reg == ST_LOOK && hdr_tagged && tci_vid != 12'h000)
		|=> out_vid_reg == {hdr_reg[14][3:0], hdr_reg[15]})
		else $error("tagged frame not classified by its tag");
	tag_insert_a: assert property (
		(head_ins && tag_cnt_reg == 2'h0)
		|=> out_data_reg == 8'(`VTC_TPID >> 8) ##1
		out_data_reg == 8'(`VTC_TPID) ##1 out_data_reg[4] == 1'b0 ##1
		out_data_reg == class_vid[7:0])
		else $error("inserted tag bytes wrong");
	tag_keep_a: assert property (
		(head_live && at_tag && hdr_tagged && !eg_untag)
		|=> out_valid_reg && out_data_reg == 8'(`VTC_TPID >> 8))
		else $error("existing tag altered on tagging port");
	tag_strip_a: assert property (
		head_skip |=> !out_valid_reg && rd_ptr_reg == `VTC_HDR_LEN ##1
		!out_valid_reg)
		else $error("tag not stripped on untagging port");
	fcs_tail_a: assert property (
		out_eop_reg |-> $past(state_reg) == ST_FCS &&
		$past(fcs_cnt_reg) == 2'h3 && $past(state_reg, 5) != ST_FCS)
		else $error("frame end not after four check bytes");
	drop_quiet_a: assert property (
		(state_reg == ST_LOOK && state_next != ST_LOOK && !look_hit)
		|=> !out_valid_reg [*2])
		else $error("non-member frame was sent");
	reset_dflt_a: assert property (
		$past(!rst_n) |-> tab_vid[0] == `VTC_RST_VID &&
		tab_mem[0] == `VTC_RST_MEMBERS && port_default_vlan_id_reg[0] == `VTC_RST_VID)
		else $error("default vlan not set after reset");
	dflt_leave_a: assert property (
		leave_dflt |=> (tab_mem[0] & $past(new_mem)) == 8'h00)
		else $error("new vlan members kept in default vlan");
	mgmt_flag_a: assert property (
		(state_reg == ST_LOOK && class_vid == mgmt_reg) |=> out_mgmt_reg)
		else $error("mgmt_vlan_select frame not flagged");
	bus_answer_a: assert property (
		(bus_req && wait_reg) |=> !avs_waitrequest ##1 avs_waitrequest)
		else $error("bus answer not a single cycle");

	ins_c: cover property (head_ins && tag_cnt_reg == 2'h3);
	strip_c: cover property (head_skip);
	drop_c: cover property (state_reg == ST_DROP);
	mgmt_c: cover property (out_sop_reg && out_mgmt_reg);
endmodule
`default_nettype wire

// ===== testbench/vtc_eth_peer.sv
// Ethernet link partner model feeding and collecting the frame stream.
`default_nettype none
module vtc_eth_peer (
	input wire logic sys_clk,
	input wire logic in_ready,
	output logic [7:0] in_data,
	output logic in_valid,
	output logic in_sop,
	output logic in_eop,
	input wire logic [7:0] out_data,
	input wire logic out_valid
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] frm[$];
	logic [7:0] rx[$];
	initial
	begin
		in_data = 8'h00;
		in_valid = 1'b0;
		in_sop = 1'b0;
		in_eop = 1'b0;
	end
	// The sink never pushes back, so every egress byte is kept.
	always @(posedge sys_clk)
	begin
		if (out_valid === 1'b1)
			rx.push_back(out_data);
	end
	// A byte is held until in_ready is seen high; the idle line then shows
	// the inverse of the last byte so stale data cannot pass for valid.
	task automatic send();
		int i;
		i = 0;
		in_data <= frm[0];
		in_valid <= 1'b1;
		in_sop <= 1'b1;
		in_eop <= (frm.size() == 1);
		while (i < frm.size())
		begin
			@(posedge sys_clk);
			if (in_ready === 1'b1)
			begin
				i++;
				in_sop <= 1'b0;
				in_eop <= (i == frm.size() - 1);
				in_data <= (i < frm.size()) ? frm[i] : ~frm[i - 1];
				in_valid <= (i < frm.size());
			end
		end
	endtask
endmodule
`default_nettype wire

// ===== testbench/vlan_tag_classify_edit_tb.sv
// Self-checking bench for the VLAN tag classifier and editor.
`default_nettype none
`include "vtc_regs.svh"
module vlan_tag_classify_edit_tb;
	timeunit 1ns;
	timeprecision 1ps;
	typedef logic [7:0] vtc_byte_q_t[$];
	logic sys_clk, rst_n, avs_read, avs_write, avs_waitrequest;
	logic [7:0] avs_address, in_data, out_data;
	logic [31:0] avs_writedata, avs_readdata, rd_q;
	logic [3:0] avs_byteenable;
	logic in_valid, in_sop, in_eop, in_ready, out_valid, out_sop, out_eop;
	logic out_canonical, out_mgmt;
	logic [2:0] out_prio;
	vtc_pkg::vtc_port_t in_port, in_egress;
	vtc_pkg::vtc_vid_t out_vid;
	logic [16:0] meta;
	int mismatches, n_tests, n_eop;
	vtc_byte_q_t b, none;
	vtc_top vtc_top_inst (.sys_clk, .rst_n, .avs_address, .avs_read,
		.avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
		.avs_waitrequest, .in_data, .in_valid, .in_sop, .in_eop, .in_port,
		.in_egress, .in_ready, .out_data, .out_valid, .out_sop, .out_eop,
		.out_vid, .out_prio, .out_canonical, .out_mgmt);
	vtc_eth_peer vtc_eth_peer_inst (.sys_clk, .in_ready, .in_data,
		.in_valid, .in_sop, .in_eop, .out_data, .out_valid);
	initial
	begin
		sys_clk = 1'b0;
		forever
			#4 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk)
	begin
		if (out_sop === 1'b1)
			meta <= {out_mgmt, out_canonical, out_prio, out_vid};
		if (out_eop === 1'b1)
			n_eop <= n_eop + 1;
	end
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			mismatches++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic stop_test();
		$display("comparisons %0d, mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		@(posedge sys_clk);
		while (avs_waitrequest !== 1'b0)
			@(posedge sys_clk);
		rd_q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		avs_address <= ~a;
		avs_writedata <= ~d;
		@(posedge sys_clk);
	endtask
	function automatic vtc_byte_q_t tag(input vtc_byte_q_t q,
		input logic [15:0] tci);
		q.insert(12, tci[7:0]);
		q.insert(12, tci[15:8]);
		q.insert(12, 8'h00);
		q.insert(12, 8'h81);
		return q;
	endfunction
	function automatic vtc_byte_q_t fin(input vtc_byte_q_t q);
		logic [31:0] c;
		c = `VTC_CRC_INIT;
		foreach (q[i])
		begin
			c = c ^ {24'h0, q[i]};
			repeat (8)
				c = c[0] ? (c >> 1) ^ `VTC_CRC_POLY : c >> 1;
		end
		c = ~c;
		for (int k = 0; k < 4; k++)
			q.push_back(c[8 * k +: 8]);
		return q;
	endfunction
	// The fixed wait covers a full table miss of 255 lookup cycles.
	task automatic run(input vtc_pkg::vtc_port_t p,
		input vtc_pkg::vtc_port_t e, input vtc_byte_q_t f,
		input vtc_byte_q_t x);
		in_port <= p;
		in_egress <= e;
		vtc_eth_peer_inst.rx.delete();
		vtc_eth_peer_inst.frm = f;
		vtc_eth_peer_inst.send();
		repeat (400)
			@(posedge sys_clk);
		check(32'(vtc_eth_peer_inst.rx.size()), 32'(x.size()));
		foreach (x[i])
			check({24'h0, vtc_eth_peer_inst.rx[i]}, {24'h0, x[i]});
	endtask
	// The whole sequence needs about 4000 cycles, well inside this span.
	initial
	begin
		#100us;
		mismatches++;
		stop_test();
	end
	initial
	begin
		rst_n = 1'b0;
		avs_address = 8'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'hf;
		in_port = 3'h0;
		in_egress = 3'h0;
		mismatches = 0;
		n_tests = 0;
		n_eop = 0;
		for (int i = 0; i < 20; i++)
			b.push_back(8'(8'h10 + i));
		repeat (20)
			@(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		bus(1'b0, `VTC_OFF_MGMT, 32'h0);
		check(rd_q, 32'h1);
		bus(1'b0, `VTC_OFF_UNTAG, 32'h0);
		check(rd_q, 32'hff);
		bus(1'b0, 8'h18, 32'h0);
		check(rd_q, 32'h0);
		for (int p = 0; p < 8; p++)
		begin
			bus(1'b0, 8'(`VTC_OFF_PORT_DEFAULT_VLAN_ID + 4 * p), 32'h0);
			check(rd_q, 32'h1);
		end
		bus(1'b0, `VTC_OFF_TDATA, 32'h0);
		check(rd_q, 32'h800ff001);
		bus(1'b1, `VTC_OFF_TIDX, 32'h1);
		bus(1'b1, `VTC_OFF_TDATA, 32'h80006005);
		bus(1'b1, `VTC_OFF_TIDX, 32'h2);
		bus(1'b1, `VTC_OFF_TDATA, 32'h80002009);
		bus(1'b0, `VTC_OFF_TDATA, 32'h0);
		check(rd_q, 32'h80002009);
		bus(1'b1, `VTC_OFF_TIDX, {24'h0, `VTC_LAST_IDX});
		bus(1'b1, `VTC_OFF_TDATA, 32'h80001ffe);
		bus(1'b0, `VTC_OFF_TDATA, 32'h0);
		check(rd_q, 32'h80001ffe);
		bus(1'b1, `VTC_OFF_TIDX, 32'h0);
		bus(1'b0, `VTC_OFF_TDATA, 32'h0);
		check(rd_q, 32'h800f8001);
		bus(1'b1, 8'h2c, 32'h5);
		bus(1'b0, 8'h2c, 32'h0);
		check(rd_q, 32'h5);
		bus(1'b1, `VTC_OFF_MGMT, 32'h5);
		bus(1'b0, `VTC_OFF_MGMT, 32'h0);
		check(rd_q, 32'h5);
		bus(1'b1, `VTC_OFF_UNTAG, 32'h4);
		bus(1'b1, `VTC_OFF_PRIO, 32'h6);
		run(3'h3, 3'h1, b, fin(tag(b, 16'hc005)));
		check({15'h0, meta}, 32'h16005);
		run(3'h3, 3'h1, tag(b, 16'hb009), fin(tag(b, 16'hb009)));
		check({15'h0, meta}, 32'h0d009);
		run(3'h3, 3'h1, tag(b, 16'h2000), fin(tag(b, 16'h2000)));
		check({15'h0, meta}, 32'h11005);
		run(3'h0, 3'h2, tag(b, 16'h4005), fin(b));
		check({15'h0, meta}, 32'h12005);
		run(3'h3, 3'h0, tag(b, 16'h0ffe), fin(tag(b, 16'h0ffe)));
		run(3'h3, 3'h2, tag(b, 16'hb009), none);
		run(3'h0, 3'h2, b, none);
		bus(1'b1, `VTC_OFF_STAT, 32'hffffffff);
		bus(1'b0, `VTC_OFF_STAT, 32'h0);
		check(rd_q, 32'h00020005);
		check(32'(n_eop), 32'h5);
		avs_byteenable <= 4'h1;
		bus(1'b1, `VTC_OFF_MGMT, 32'h00000f07);
		avs_byteenable <= 4'hf;
		bus(1'b0, `VTC_OFF_MGMT, 32'h0);
		check(rd_q, 32'h7);
		stop_test();
	end
endmodule
`default_nettype wire
